//--- hw/fcs_host.sv
// fcs_host: host controller that drives a byte-wide chip-erasable flash
// through its strobe pins and command latch.
// assumes: flash pins are sampled synchronously to clk_sys; the board
// drives the programming supply from supply_high_level.
`timescale 1ns/1ps
`default_nettype none
module fcs_host #(
    parameter int PROG_WAIT  = fcs_pkg::PROG_PULSE_CYC,
    parameter int ERASE_WAIT = fcs_pkg::ERASE_PULSE_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // user command port
    input  wire logic        op_valid,
    output logic             op_ready,
    input  wire fcs_pkg::fcs_op_t op_code,
    input  wire logic [14:0] op_addr,
    input  wire logic [7:0]  op_wdata,
    output logic             done_pulse,
    output logic [7:0]       rd_data_q,
    output logic             erased_q,
    output logic             refused_q,
    // programming supply enable
    output logic             supply_high_level,
    // flash pins
    output logic             chip_sel_n,
    output logic             out_drive_n,
    output logic             write_n,
    output logic [14:0]      addr_out,
    input  wire logic [7:0]  data_lines_i,
    output logic [7:0]       data_lines_o,
    output logic             data_lines_oe
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_WAIT
    } fcs_state_t;

    fcs_state_t          st_q, st_d;
    logic [15:0]         cnt_q, cnt_d;
    logic [23:0]         wait_q, wait_d;
    logic [1:0]          step_q, step_d;
    logic                rd_q, rd_d;
    fcs_pkg::fcs_op_t    op_q, op_d;
    logic [14:0]         addr_q, addr_d;
    logic [7:0]          wdata_q, wdata_d;
    logic [7:0]          bus_q, bus_d;
    logic [7:0]          rdat_d;
    logic                er_d, ref_d, done_d, sup_q, sup_d;

    // ------------------------------------------------------------------
    // sequence table: per op, the number of write cycles and the byte of each
    // ------------------------------------------------------------------
    function automatic logic [1:0] fcs_writes(input fcs_pkg::fcs_op_t o);
        case (o)
            fcs_pkg::OP_READ:      fcs_writes = 2'd1;
            fcs_pkg::OP_IDENT:     fcs_writes = 2'd1;
            fcs_pkg::OP_ERASE:     fcs_writes = 2'd2;
            fcs_pkg::OP_ERASE_VFY: fcs_writes = 2'd1;
            fcs_pkg::OP_PROG:      fcs_writes = 2'd2;
            fcs_pkg::OP_PROG_VFY:  fcs_writes = 2'd1;
            fcs_pkg::OP_RESET:     fcs_writes = 2'd2;
            default:               fcs_writes = 2'd1;
        endcase
    endfunction

    function automatic logic [7:0] fcs_byte(input fcs_pkg::fcs_op_t o,
                                            input logic [1:0] s,
                                            input logic [7:0] wd);
        case (o)
            fcs_pkg::OP_READ:      fcs_byte = fcs_pkg::CMD_READ;
            fcs_pkg::OP_IDENT:     fcs_byte = fcs_pkg::CMD_IDENT;
            fcs_pkg::OP_ERASE:     fcs_byte = fcs_pkg::CMD_ERASE;
            fcs_pkg::OP_ERASE_VFY: fcs_byte = fcs_pkg::CMD_ERASE_VFY;
            fcs_pkg::OP_PROG:      fcs_byte = (s == 2'd0) ?
                                       fcs_pkg::CMD_PROG : wd;
            fcs_pkg::OP_PROG_VFY:  fcs_byte = fcs_pkg::CMD_PROG_VFY;
            fcs_pkg::OP_RESET:     fcs_byte = fcs_pkg::CMD_RESET;
            default:               fcs_byte = wd;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // bus sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        wait_d  = wait_q;
        step_d  = step_q;
        rd_d    = rd_q;
        op_d    = op_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        bus_d   = bus_q;
        rdat_d  = rd_data_q;
        er_d    = erased_q;
        ref_d   = refused_q;
        done_d  = 1'b0;
        sup_d   = sup_q;
        case (st_q)
            ST_IDLE: begin
                if (op_valid) begin
                    op_d    = op_code;
                    addr_d  = op_addr;
                    wdata_d = op_wdata;
                    step_d  = 2'd0;
                    cnt_d   = 16'(fcs_pkg::SETUP_CYC);
                    ref_d   = 1'b0;
                    if (op_code == fcs_pkg::OP_READ && !sup_q) begin
                        // plain read with supply low: read-only memory
                        rd_d  = 1'b1;
                        st_d  = ST_SETUP;
                    end else if (!sup_q) begin
                        // supply is raised and op refused; caller reissues it
                        sup_d = 1'b1;
                        ref_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        rd_d  = 1'b0;
                        st_d  = ST_SETUP;
                        bus_d = fcs_byte(op_code, 2'd0, op_wdata);
                    end
                end
            end
            ST_SETUP: begin
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    st_d  = ST_STROBE;
                    cnt_d = rd_q ? 16'(fcs_pkg::READ_CYC)
                                 : 16'(fcs_pkg::STROBE_CYC);
                end
            end
            ST_STROBE: begin
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    if (rd_q) begin
                        rdat_d = data_lines_i;
                        er_d   = (data_lines_i == fcs_pkg::ERASED_BYTE);
                    end
                    st_d  = ST_HOLD;
                    cnt_d = 16'(fcs_pkg::HOLD_CYC);
                end
            end
            ST_HOLD: begin
                cnt_d = cnt_q - 16'd1;
                if (cnt_q == 16'd0) begin
                    if (!rd_q && step_q + 2'd1 < fcs_writes(op_q)) begin
                        step_d = step_q + 2'd1;
                        bus_d  = fcs_byte(op_q, step_q + 2'd1, wdata_q);
                        st_d   = ST_SETUP;
                        cnt_d  = 16'(fcs_pkg::SETUP_CYC);
                    end else if (!rd_q && (op_q == fcs_pkg::OP_ERASE ||
                                           op_q == fcs_pkg::OP_PROG)) begin
                        // pulse runs deselected; verify write ends it
                        st_d   = ST_WAIT;
                        wait_d = (op_q == fcs_pkg::OP_ERASE) ?
                                 24'(ERASE_WAIT) : 24'(PROG_WAIT);
                    end else if (!rd_q && (op_q == fcs_pkg::OP_READ ||
                                           op_q == fcs_pkg::OP_IDENT ||
                                           op_q == fcs_pkg::OP_ERASE_VFY ||
                                           op_q == fcs_pkg::OP_PROG_VFY))
                    begin
                        rd_d  = 1'b1;
                        st_d  = ST_SETUP;
                        cnt_d = 16'(fcs_pkg::SETUP_CYC);
                    end else begin
                        st_d   = ST_IDLE;
                        done_d = 1'b1;
                        rd_d   = 1'b0;
                    end
                end
            end
            ST_WAIT: begin
                wait_d = wait_q - 24'd1;
                if (wait_q == 24'd0) begin
                    st_d   = ST_IDLE;
                    done_d = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q      <= ST_IDLE;
            cnt_q     <= 16'h0000;
            wait_q    <= 24'h000000;
            step_q    <= 2'h0;
            rd_q      <= 1'b0;
            op_q      <= fcs_pkg::OP_READ;
            addr_q    <= 15'h0000;
            wdata_q   <= 8'h00;
            bus_q     <= 8'h00;
            rd_data_q <= 8'h00;
            erased_q  <= 1'b0;
            refused_q <= 1'b0;
            done_pulse <= 1'b0;
            sup_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            wait_q    <= wait_d;
            step_q    <= step_d;
            rd_q      <= rd_d;
            op_q      <= op_d;
            addr_q    <= addr_d;
            wdata_q   <= wdata_d;
            bus_q     <= bus_d;
            rd_data_q <= rdat_d;
            erased_q  <= er_d;
            refused_q <= ref_d;
            done_pulse <= done_d;
            sup_q     <= sup_d;
        end
    end

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    logic active;
    assign active   = (st_q == ST_SETUP) || (st_q == ST_STROBE) ||
                      (st_q == ST_HOLD);
    assign op_ready = (st_q == ST_IDLE);
    assign supply_high_level = sup_q;
    // idle and pulse wait are standby with data floating
    assign chip_sel_n  = !active;
    assign out_drive_n = !(rd_q && st_q == ST_STROBE);
    // address set before strobe fall, data held past rise
    assign write_n     = !(!rd_q && st_q == ST_STROBE);
    assign addr_out    = addr_q;
    assign data_lines_o  = bus_q;
    assign data_lines_oe = active && !rd_q;
endmodule
`default_nettype wire

//--- inc/fcs_pkg.sv
// fcs_pkg: command codes, bus timing counts and host op codes for the
// flash command host controller.
// assumes: one 100 MHz clock; the flash sits directly on the host pins.
package fcs_pkg;
    // ------------------------------------------------------------------
    // flash command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ       = 8'h00;
    localparam logic [7:0] CMD_IDENT      = 8'h90;
    localparam logic [7:0] CMD_ERASE      = 8'h20;
    localparam logic [7:0] CMD_ERASE_VFY  = 8'ha0;
    localparam logic [7:0] CMD_PROG       = 8'h40;
    localparam logic [7:0] CMD_PROG_VFY   = 8'hc0;
    localparam logic [7:0] CMD_RESET      = 8'hff;
    localparam logic [7:0] ERASED_BYTE    = 8'hff;

    // ------------------------------------------------------------------
    // identifier addresses
    // ------------------------------------------------------------------
    localparam logic [14:0] ID_MFR_ADDR   = 15'h0000;
    localparam logic [14:0] ID_DEV_ADDR   = 15'h0001;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // timing: strobe phase lengths in ns and cycles at 100 MHz
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SETUP_NS       = 20;
    localparam int STROBE_NS      = 60;
    localparam int READ_NS        = 150;
    localparam int HOLD_NS        = 20;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC   = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W      = 16;

    // minimum pulse lengths, in us; parameters of the top shorten them
    localparam int PROG_PULSE_US  = 10;
    localparam int ERASE_PULSE_US = 10000;
    localparam int PROG_PULSE_CYC  = PROG_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int ERASE_PULSE_CYC = ERASE_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int WAIT_W = 24;

    // ------------------------------------------------------------------
    // host operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ,
        OP_IDENT,
        OP_ERASE,
        OP_ERASE_VFY,
        OP_PROG,
        OP_PROG_VFY,
        OP_RESET,
        OP_WRITE_RAW
    } fcs_op_t;
endpackage

//--- dv/fcs_host_properties.sv
// fcs_host_properties: pin-level checks on the flash host controller.
// assumes: bound to fcs_host; one clock, rst synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module fcs_host_checker (
    // clock and reset
    input wire logic             clk_sys,
    input wire logic             rst,
    // user side
    input wire logic             op_valid,
    input wire logic             op_ready,
    input wire fcs_pkg::fcs_op_t op_code,
    input wire logic             done_pulse,
    // flash pins
    input wire logic             supply_high_level,
    input wire logic             chip_sel_n,
    input wire logic             out_drive_n,
    input wire logic             write_n,
    input wire logic [14:0]      addr_out,
    input wire logic [7:0]       data_lines_o,
    input wire logic             data_lines_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // read strobe length counter
    // ------------------------------------------------------------------
    logic [7:0] rd_len_q;
    always_ff @(posedge clk_sys) begin
        if (rst || out_drive_n) begin
            rd_len_q <= 8'h00;
        end else begin
            rd_len_q <= rd_len_q + 8'h01;
        end
    end

    AST_READ_PINS: assert property (
        !out_drive_n |-> !chip_sel_n && write_n)
        else $error("output drive without select or during write");
    AST_FLOAT_ON_READ: assert property (
        !out_drive_n |-> !data_lines_oe)
        else $error("host drives data while flash outputs");
    AST_WRITE_PINS: assert property (
        !write_n |-> !chip_sel_n && out_drive_n && data_lines_oe)
        else $error("write strobe without select or data");
    AST_ADDR_HELD: assert property (
        !write_n && !$past(write_n) |-> $stable(addr_out))
        else $error("address moved under write strobe");
    AST_DATA_HELD: assert property (
        $rose(write_n) |-> data_lines_oe && $stable(data_lines_o))
        else $error("data not held at strobe rise");
    AST_STROBE_LEN: assert property (
        $fell(write_n) |-> (!write_n) [*7] ##1 write_n)
        else $error("write strobe length wrong");
    AST_NO_WRITE_LOW: assert property (
        !supply_high_level |-> write_n)
        else $error("write issued with supply low");
    AST_REFUSE: assert property (
        op_valid && op_ready && !supply_high_level
        && op_code != fcs_pkg::OP_READ |-> ##1 done_pulse)
        else $error("refused op not answered");
    AST_READ_LEN: assert property (
        $fell(out_drive_n) |-> (!out_drive_n) [*8])
        else $error("read strobe too short");
    AST_READ_TOTAL: assert property (
        $rose(out_drive_n) |-> rd_len_q == 8'(fcs_pkg::READ_CYC + 1))
        else $error("read strobe length not as set");

    COV_READ: cover property ($fell(out_drive_n));
    COV_WRITE: cover property ($rose(write_n));
    COV_REFUSE: cover property (op_valid && op_ready && !supply_high_level);
endmodule
bind fcs_host fcs_host_checker i_fcs_host_checker (.clk_sys(clk_sys), .rst(rst),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .done_pulse(done_pulse), .supply_high_level(supply_high_level),
    .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n), .write_n(write_n),
    .addr_out(addr_out), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe));
`default_nettype wire

//--- dv/fcs_flash_model.sv
// fcs_flash_model: behavioural byte-wide flash with command latch.
// assumes: strobe driven, no clock; erase and program finish at once.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
    parameter logic [7:0] MFR_CODE = 8'h5e, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h6b, // arbitrary value
    parameter int         ACC_NS   = 120
) (
    // supply and strobes
    input wire logic        supply_high_level,
    input wire logic        chip_sel_n,
    input wire logic        out_drive_n,
    input wire logic        write_n,
    input wire logic [14:0] addr,
    // data lines
    input wire logic [7:0]  dq_in,
    output logic [7:0]      dq_out,
    output logic            dq_oe
);
    logic [7:0]  mem [0:32767];
    logic [1:0]  mode;  // array, ident, erase verify, program verify
    logic [1:0]  setup; // none, erase, program, reset
    logic [14:0] wa;
    logic [14:0] program_address;
    logic [14:0] erase_verify_address;
    logic [7:0]  rd_val;
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'h3c;
        mode = 2'h0;
        setup = 2'h0;
    end
    always @(negedge write_n) if (!chip_sel_n) wa = addr;
    always @(posedge write_n or negedge supply_high_level) begin
        if (!supply_high_level) begin
            mode = 2'h0;
            setup = 2'h0;
        end else if (!chip_sel_n) begin
            if (setup == 2'h2 && dq_in != 8'hff) begin
                mem[wa] = mem[wa] & dq_in;
                program_address = wa;
                setup = 2'h0;
            end else if (setup == 2'h1) begin
                if (dq_in == 8'h20) begin
                    // erase finishes at once, so a later deselect cannot cut it
                    for (int i = 0; i < 32768; i++) begin
                        mem[i] = 8'hff;
                    end
                end
                setup = 2'h0;
            end else if (setup == 2'h3) begin
                if (dq_in == 8'hff) mode = 2'h0;
                setup = 2'h0;
            end else begin
                setup = 2'h0;
                case (dq_in)
                    8'h00: mode = 2'h0;
                    8'h90: mode = 2'h1;
                    8'h20: setup = 2'h1;
                    8'h40: setup = 2'h2;
                    8'ha0: begin
                        mode = 2'h2;
                        erase_verify_address = wa;
                    end
                    8'hc0: mode = 2'h3;
                    8'hff: setup = 2'h3;
                    default: ;
                endcase
            end
        end
    end
    always_comb begin
        case (mode)
            2'h1: rd_val = addr[0] ? DEV_CODE : MFR_CODE;
            2'h2: rd_val = mem[erase_verify_address];
            2'h3: rd_val = mem[program_address];
            default: rd_val = mem[addr];
        endcase
    end
    assign dq_oe = !chip_sel_n && !out_drive_n && write_n;
    // access time lag: data settles well before the host samples
    assign #ACC_NS dq_out = rd_val;
endmodule
`default_nettype wire

//--- dv/fcs_host_tb.sv
// fcs_host_tb: directed scenarios for the flash host controller.
// assumes: fcs_flash_model on the pins; shortened pulse waits.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    $display("unexpected %s expected %h seen %h", nm, ex, got); \
    err_total++; end end
module fcs_host_tb;
    localparam logic [7:0] MFR = 8'h5e; // arbitrary value
    localparam logic [7:0] DEV = 8'h6b; // arbitrary value
    logic             clk_sys = 1'b0;
    logic             rst = 1'b1;
    logic             op_valid = 1'b0;
    fcs_pkg::fcs_op_t op_code = fcs_pkg::OP_READ;
    logic [14:0]      op_addr = 15'h0000;
    logic [7:0]       op_wdata = 8'h00;
    logic             op_ready, done_pulse, erased_q, refused_q;
    logic [7:0]       rd_data_q, data_lines_o, f_dq;
    logic [7:0]       last_q = 8'h00;
    logic             supply_high_level, chip_sel_n, out_drive_n, write_n;
    logic             data_lines_oe, f_oe;
    logic [14:0]      addr_out;
    wire  [7:0]       data_lines_i;
    int               err_total = 0;
    int               check_count = 0;

    always #5 clk_sys = ~clk_sys;
    // released bus shows the inverse of its last value
    assign data_lines_i = f_oe ? f_dq
                        : (data_lines_oe ? data_lines_o : ~last_q);
    always @(posedge clk_sys) if (f_oe || data_lines_oe) last_q <= data_lines_i;

    fcs_host #(.PROG_WAIT(20), .ERASE_WAIT(20)) i_fcs_host (.clk_sys(clk_sys),
        .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
        .op_addr(op_addr), .op_wdata(op_wdata), .done_pulse(done_pulse),
        .rd_data_q(rd_data_q), .erased_q(erased_q), .refused_q(refused_q),
        .supply_high_level(supply_high_level), .chip_sel_n(chip_sel_n),
        .out_drive_n(out_drive_n), .write_n(write_n), .addr_out(addr_out),
        .data_lines_i(data_lines_i), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe));
    fcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .ACC_NS(120))
        i_fcs_flash_model (.supply_high_level(supply_high_level),
        .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n), .write_n(write_n),
        .addr(addr_out), .dq_in(data_lines_i), .dq_out(f_dq), .dq_oe(f_oe));

    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_op(input fcs_pkg::fcs_op_t c, input logic [14:0] a,
                         input logic [7:0] d);
        int n;
        op_valid <= 1'b1;
        op_code <= c;
        op_addr <= a;
        op_wdata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (op_ready !== 1'b1 && n < 50);
        op_valid <= 1'b0;
        if (op_ready !== 1'b1) begin
            err_total++;
            results();
        end
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (done_pulse !== 1'b1 && n < 3000);
        if (done_pulse !== 1'b1) begin
            err_total++;
            results();
        end
    endtask

    task automatic t_read_only;
        `CHK("supply", 1'b0, supply_high_level)
        do_op(fcs_pkg::OP_READ, 15'h0005, 8'h00);
        `CHK("plain read", 8'h39, rd_data_q)
        do_op(fcs_pkg::OP_PROG, 15'h0003, 8'h00);
        `CHK("refused", 1'b1, refused_q)
        `CHK("supply up", 1'b1, supply_high_level)
        do_op(fcs_pkg::OP_READ, 15'h0003, 8'h00);
        `CHK("untouched", 8'h3f, rd_data_q)
        `CHK("not refused", 1'b0, refused_q)
        $display("test read_only done");
    endtask

    task automatic t_ident;
        do_op(fcs_pkg::OP_IDENT, 15'h0000, 8'h00);
        `CHK("maker code", MFR, rd_data_q)
        do_op(fcs_pkg::OP_IDENT, 15'h0001, 8'h00);
        `CHK("device code", DEV, rd_data_q)
        $display("test ident done");
    endtask

    task automatic t_program;
        do_op(fcs_pkg::OP_PROG, 15'h0007, 8'h12);
        do_op(fcs_pkg::OP_PROG_VFY, 15'h0055, 8'h00);
        `CHK("program verify", 8'h12, rd_data_q)
        do_op(fcs_pkg::OP_READ, 15'h0007, 8'h00);
        `CHK("programmed", 8'h12, rd_data_q)
        `CHK("not erased", 1'b0, erased_q)
        $display("test program done");
    endtask

    task automatic t_abort;
        do_op(fcs_pkg::OP_WRITE_RAW, 15'h0009, 8'h40);
        do_op(fcs_pkg::OP_RESET, 15'h0009, 8'h00);
        do_op(fcs_pkg::OP_READ, 15'h0009, 8'h00);
        `CHK("after abort", 8'h35, rd_data_q)
        $display("test abort done");
    endtask

    task automatic t_erase;
        do_op(fcs_pkg::OP_WRITE_RAW, 15'h0000, 8'h20);
        do_op(fcs_pkg::OP_READ, 15'h0002, 8'h00);
        `CHK("single setup", 8'h3e, rd_data_q)
        do_op(fcs_pkg::OP_ERASE, 15'h0000, 8'h00);
        do_op(fcs_pkg::OP_ERASE_VFY, 15'h0007, 8'h00);
        `CHK("erase verify", 8'hff, rd_data_q)
        `CHK("erased flag", 1'b1, erased_q)
        do_op(fcs_pkg::OP_READ, 15'h0007, 8'h00);
        `CHK("erased read", 8'hff, rd_data_q)
        $display("test erase done");
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_read_only();
        t_ident();
        t_program();
        t_abort();
        t_erase();
        results();
    end
endmodule
`default_nettype wire
